// ===== common/pcg_map.svh
// Offsets, field positions, masks and reset values of the peripheral clock gating block.
// Assumes inclusion by bare name from files that need the register map.
`ifndef PCG_MAP_SVH
`define PCG_MAP_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PCG_OFF_CFG 12'h060
`define PCG_OFF_RUN1 12'h100
`define PCG_OFF_RUN2 12'h104
`define PCG_OFF_DEEP1 12'h120
`define PCG_OFF_STAT 12'h130

// ----------------------------------------------------------------
// Writable masks and reset values
// ----------------------------------------------------------------
`define PCG_MASK_RUN1 32'h0000_0008
`define PCG_MASK_RUN2 32'h0107_1013
`define PCG_MASK_DEEP1 32'h0000_0008
`define PCG_MASK_CFG 32'h0000_0001
`define PCG_RST_GATE 32'h0000_0000

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PCG_BIT_WDT 3
`define PCG_BIT_ASYNC_SERIAL_A_CLK_GATE 0
`define PCG_BIT_ASYNC_SERIAL_B_CLK_GATE 1
`define PCG_BIT_SYNC_SERIAL_A_CLK_GATE 4
`define PCG_BIT_TWI0 12
`define PCG_BIT_TMR0 16
`define PCG_BIT_TMR1 17
`define PCG_BIT_TMR2 18
`define PCG_BIT_CMP0 24
`define PCG_BIT_ACG 0
`define PCG_BIT_FAULT 16
`define PCG_FUNIT_LSB 20

// ----------------------------------------------------------------
// Unit count and width of a unit index
// ----------------------------------------------------------------
`define PCG_NUM_UNITS 9
`define PCG_UNIT_W 4

`endif

// ===== common/pcg_pkg.sv
// Types shared by the peripheral clock gating block.
// Assumes pcg_map.svh is on the include path.
`include "pcg_map.svh"

package pcg_pkg;

  // ----------------------------------------------------------------
  // Power modes and the per-unit gate carrier
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {PCG_RUN, PCG_SLEEP, PCG_DEEP} pcg_mode_e;

  // Bit 0 is the watchdog, bit 8 the analog comparator.
  typedef struct packed {
    logic cmp0;
    logic gp_counter_c_clk_gate;
    logic gp_counter_b_clk_gate;
    logic gp_counter_a_clk_gate;
    logic twowire_port_a_clk_gate;
    logic sync_serial_a_clk_gate;
    logic async_serial_b_clk_gate;
    logic async_serial_a_clk_gate;
    logic watchdog_clk_gate;
  } pcg_gates_s;

  typedef logic [`PCG_NUM_UNITS-1:0] pcg_gvec_t;

endpackage : pcg_pkg

// ===== logic/pcg_gate_sel.sv
// One unit's clock enable, chosen from the run, sleep and deep-sleep gate bits.
// Assumes mode and gate inputs are synchronous to pclk.
`timescale 1ns/1ps
`default_nettype none

module pcg_gate_sel
  import pcg_pkg::*;
(
  input wire logic pclk, // System clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire pcg_mode_e mode, // Current power mode.
  input wire logic auto_clock_gating_bit, // Automatic gating enable.
  input wire logic run_bit, // Run-mode gate bit.
  input wire logic sleep_bit, // Sleep-mode gate bit.
  input wire logic deep_bit, // Deep-sleep gate bit.
  output logic en_r // Registered clock enable.
);

  logic en_nxt;

  // Low-power sets only count with automatic gating on; otherwise run bits stay.
  always_comb begin
    en_nxt = run_bit;
    if (auto_clock_gating_bit) begin
      case (mode)
        PCG_SLEEP: en_nxt = sleep_bit;
        PCG_DEEP: en_nxt = deep_bit;
        default: en_nxt = run_bit;
      endcase
    end
  end

  // Enable register; a low enable withholds the unit's clock.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_r <= 1'b0;
    end else begin
      en_r <= en_nxt;
    end
  end

endmodule : pcg_gate_sel

`default_nettype wire

// ===== logic/pcg_fault_chk.sv
// Bus fault detection for accesses aimed at a unit whose clock is off.
// Assumes access strobe and unit index are synchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
`include "pcg_map.svh"

module pcg_fault_chk
  import pcg_pkg::*;
(
  input wire logic pclk, // System clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic acc_valid, // Access to a peripheral this cycle.
  input wire logic [`PCG_UNIT_W-1:0] acc_unit, // Index of the unit accessed.
  input wire pcg_gvec_t en_vec, // Current clock enables.
  output logic fault_r, // One-cycle bus fault pulse.
  output logic [`PCG_UNIT_W-1:0] funit_r // Unit of the last fault.
);

  logic hit;

  // Indices beyond the gated units are never faulted.
  always_comb begin
    hit = 1'b0;
    if (acc_valid && (acc_unit < `PCG_UNIT_W'(`PCG_NUM_UNITS))) begin
      hit = !en_vec[acc_unit];
    end
  end

  // Fault pulse and the unit it belongs to.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_r <= 1'b0;
      funit_r <= '0;
    end else begin
      fault_r <= hit;
      if (hit) begin
        funit_r <= acc_unit;
      end
    end
  end

endmodule : pcg_fault_chk

`default_nettype wire

// ===== logic/pcg_ctrl.sv
// Peripheral clock gating controller with an APB register slave.
// Assumes one clock, APB master on pclk, power mode requests on pclk.
//
// What this block does
// - Set gate bit delivers clock to unit.
// - Clear gate bit withholds clock, unit disabled.
// - Access to unclocked unit gives bus fault.
// - All gate bits reset to zero.
// - Run, sleep, deep-sleep sets per mode.
// - Low-power sets only with automatic gating.
// - Deep-sleep first register: bit 3 watchdog.
// - Run second register bits 18:16 timers.
// - Run second register bit 12 two-wire.
// - Run second register bit 4 sync serial.
// - Run second register bits 1:0 async serial.
// - Unused run second bits read zero.
// - Run second register gates analog comparator.
`timescale 1ns/1ps
`default_nettype none
`include "pcg_map.svh"

module pcg_ctrl
  import pcg_pkg::*;
#(
  parameter int ADDR_W = 12 // APB address width.
) (
  input wire logic pclk, // System clock, 200 MHz.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB write.
  input wire logic [ADDR_W-1:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  input wire logic [3:0] pstrb, // APB write byte strobes.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error.
  input wire logic sleep_req, // Processor is in sleep.
  input wire logic deep_sleep_req, // Processor is in deep sleep.
  input wire pcg_gates_s sleep_gates, // Sleep-mode gate set.
  input wire pcg_gates_s deep_sleep_gates, // Deep-sleep set; watchdog field unused.
  input wire logic periph_acc_valid, // Peripheral access strobe.
  input wire logic [`PCG_UNIT_W-1:0] periph_acc_unit, // Peripheral index.
  output pcg_gates_s unit_clk_en, // Per-unit clock enables.
  output logic bus_fault, // Bus fault pulse.
  output logic [`PCG_UNIT_W-1:0] fault_unit // Unit of last fault.
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------

  // The decode compares the low twelve address bits, so it needs all twelve.
  if (ADDR_W < 12) begin : g_addr_chk
    $error("pcg_ctrl: ADDR_W must be at least 12");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [31:0] run1_r;
  logic [31:0] run2_r;
  logic [31:0] deep1_r;
  logic [31:0] cfg_r;
  logic fault_sticky_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  pcg_mode_e mode_r;
  pcg_mode_e mode_nxt;
  logic auto_clock_gating_bit;
  logic setup;
  logic fire;
  logic hi_zero;
  logic sel_run1;
  logic sel_run2;
  logic sel_deep1;
  logic sel_cfg;
  logic sel_stat;
  logic mapped;
  logic [31:0] rd_mux;
  logic wr_run1;
  logic wr_run2;
  logic wr_deep1;
  logic wr_cfg;
  logic wr_stat;
  logic fault_pulse;
  logic [`PCG_UNIT_W-1:0] funit;
  pcg_gates_s run_gates;
  pcg_gates_s deep_gates;
  pcg_gvec_t run_vec;
  pcg_gvec_t sleep_vec;
  pcg_gvec_t deep_vec;
  pcg_gvec_t en_vec;

  // ----------------------------------------------------------------
  // Byte-lane merge
  // ----------------------------------------------------------------

  // Only strobed lanes change, and only writable bits; reserved bits stay zero.
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] strb,
                                        input logic [31:0] mask);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return res & mask;
  endfunction : merge

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------

  // Upper address bits beyond the map must be zero for a hit.
  assign hi_zero = (paddr >> 12) == '0;
  assign sel_run1 = hi_zero && (paddr[11:0] == `PCG_OFF_RUN1);
  assign sel_run2 = hi_zero && (paddr[11:0] == `PCG_OFF_RUN2);
  assign sel_deep1 = hi_zero && (paddr[11:0] == `PCG_OFF_DEEP1);
  assign sel_cfg = hi_zero && (paddr[11:0] == `PCG_OFF_CFG);
  assign sel_stat = hi_zero && (paddr[11:0] == `PCG_OFF_STAT);
  assign mapped = sel_run1 || sel_run2 || sel_deep1 || sel_cfg || sel_stat;

  // Setup cycle arms the answer; the access cycle that sees pready completes.
  assign setup = psel && !penable;
  assign fire = psel && penable && pready_r;

  // Write strobes act only at the completing edge and never on an error.
  assign wr_run1 = fire && pwrite && sel_run1;
  assign wr_run2 = fire && pwrite && sel_run2;
  assign wr_deep1 = fire && pwrite && sel_deep1;
  assign wr_cfg = fire && pwrite && sel_cfg;
  assign wr_stat = fire && pwrite && sel_stat && pstrb[2];

  // Read multiplexer; reserved fields read zero through the stored masks.
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (1'b1)
      sel_run1: rd_mux = run1_r;
      sel_run2: rd_mux = run2_r;
      sel_deep1: rd_mux = deep1_r;
      sel_cfg: rd_mux = cfg_r;
      sel_stat: begin
        rd_mux[`PCG_NUM_UNITS-1:0] = en_vec;
        rd_mux[`PCG_BIT_FAULT] = fault_sticky_r;
        rd_mux[`PCG_FUNIT_LSB +: `PCG_UNIT_W] = funit;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // APB answer registers
  // ----------------------------------------------------------------

  // Ready rises for the first access cycle, so every transfer has no wait state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= setup;
    end
  end

  // Error is prepared in setup so that it stands with ready.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_r <= 1'b0;
    end else if (setup) begin
      pslverr_r <= !mapped;
    end else begin
      pslverr_r <= 1'b0;
    end
  end

  // Read data is captured in setup; it holds zero outside a read.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata_r <= rd_mux;
    end else if (fire) begin
      prdata_r <= 32'h0000_0000;
    end
  end

  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign prdata = prdata_r;

  // ----------------------------------------------------------------
  // Gate registers
  // ----------------------------------------------------------------

  // Run-mode first register holds only the watchdog gate.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run1_r <= `PCG_RST_GATE;
    end else if (wr_run1) begin
      run1_r <= merge(run1_r, pwdata, pstrb, `PCG_MASK_RUN1);
    end
  end

  // Run-mode second register: timers, two-wire, serial and comparator gates.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run2_r <= `PCG_RST_GATE;
    end else if (wr_run2) begin
      run2_r <= merge(run2_r, pwdata, pstrb, `PCG_MASK_RUN2);
    end
  end

  // Deep-sleep first register: bit 3 only, the rest is read-only zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      deep1_r <= `PCG_RST_GATE;
    end else if (wr_deep1) begin
      deep1_r <= merge(deep1_r, pwdata, pstrb, `PCG_MASK_DEEP1);
    end
  end

  // Configuration register carrying the automatic gating bit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= `PCG_RST_GATE;
    end else if (wr_cfg) begin
      cfg_r <= merge(cfg_r, pwdata, pstrb, `PCG_MASK_CFG);
    end
  end

  assign auto_clock_gating_bit = cfg_r[`PCG_BIT_ACG];

  // ----------------------------------------------------------------
  // Fault status
  // ----------------------------------------------------------------

  // Sticky fault flag, write one to clear; a new fault in the clear cycle wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_sticky_r <= 1'b0;
    end else if (fault_pulse) begin
      fault_sticky_r <= 1'b1;
    end else if (wr_stat && pwdata[`PCG_BIT_FAULT]) begin
      fault_sticky_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Power mode tracking
  // ----------------------------------------------------------------

  // Deep sleep takes precedence when both requests are high.
  always_comb begin
    mode_nxt = PCG_RUN;
    if (deep_sleep_req) begin
      mode_nxt = PCG_DEEP;
    end else if (sleep_req) begin
      mode_nxt = PCG_SLEEP;
    end
  end

  // Mode is registered so that all unit enables switch on the same edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= PCG_RUN;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Gate sets per mode
  // ----------------------------------------------------------------

  // Run set drawn from the two run registers at their fixed positions.
  always_comb begin
    run_gates = '0;
    run_gates.watchdog_clk_gate = run1_r[`PCG_BIT_WDT];
    run_gates.async_serial_a_clk_gate = run2_r[`PCG_BIT_ASYNC_SERIAL_A_CLK_GATE];
    run_gates.async_serial_b_clk_gate = run2_r[`PCG_BIT_ASYNC_SERIAL_B_CLK_GATE];
    run_gates.sync_serial_a_clk_gate = run2_r[`PCG_BIT_SYNC_SERIAL_A_CLK_GATE];
    run_gates.twowire_port_a_clk_gate = run2_r[`PCG_BIT_TWI0];
    run_gates.gp_counter_a_clk_gate = run2_r[`PCG_BIT_TMR0];
    run_gates.gp_counter_b_clk_gate = run2_r[`PCG_BIT_TMR1];
    run_gates.gp_counter_c_clk_gate = run2_r[`PCG_BIT_TMR2];
    run_gates.cmp0 = run2_r[`PCG_BIT_CMP0];
  end

  // Deep-sleep set: watchdog from the local register, the rest from outside.
  always_comb begin
    deep_gates = deep_sleep_gates;
    deep_gates.watchdog_clk_gate = deep1_r[`PCG_BIT_WDT];
  end

  assign run_vec = run_gates;
  assign sleep_vec = sleep_gates;
  assign deep_vec = deep_gates;

  // ----------------------------------------------------------------
  // Per-unit enable selection
  // ----------------------------------------------------------------

  // One selector per unit; each output is a flip-flop driving the enable pin.
  for (genvar u = 0; u < `PCG_NUM_UNITS; u++) begin : g_unit
    pcg_gate_sel u_sel (
      .pclk(pclk),
      .presetn(presetn),
      .mode(mode_r),
      .auto_clock_gating_bit(auto_clock_gating_bit),
      .run_bit(run_vec[u]),
      .sleep_bit(sleep_vec[u]),
      .deep_bit(deep_vec[u]),
      .en_r(en_vec[u])
    );
  end

  // The enables gate each unit's clock: high delivers it, low withholds it.
  assign unit_clk_en = en_vec;

  // ----------------------------------------------------------------
  // Bus fault on access to an unclocked unit
  // ----------------------------------------------------------------

  // Checked against the enables in force, so low-power gating faults too.
  pcg_fault_chk u_fault (
    .pclk(pclk),
    .presetn(presetn),
    .acc_valid(periph_acc_valid),
    .acc_unit(periph_acc_unit),
    .en_vec(en_vec),
    .fault_r(fault_pulse),
    .funit_r(funit)
  );

  assign bus_fault = fault_pulse;
  assign fault_unit = funit;

endmodule : pcg_ctrl

`default_nettype wire

// ===== testbench/pcg_ctrl_checker.sv
// Port-level assertions for the clock gating controller.
// Assumes the pcg_ctrl ports and the register map header.
`timescale 1ns/1ps
`default_nettype none
`include "pcg_map.svh"

module pcg_ctrl_checker
  import pcg_pkg::*;
#(
  parameter int ADDR_W = 12 // APB address width.
) (
  input wire logic pclk, // System clock.
  input wire logic presetn, // Reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB write.
  input wire logic [ADDR_W-1:0] paddr, // APB address.
  input wire logic [31:0] pwdata, // APB write data.
  input wire logic [3:0] pstrb, // APB strobes.
  input wire logic [31:0] prdata, // APB read data.
  input wire logic pready, // APB ready.
  input wire logic pslverr, // APB error.
  input wire logic sleep_req, // Sleep level.
  input wire logic deep_sleep_req, // Deep-sleep level.
  input wire logic periph_acc_valid, // Access strobe.
  input wire logic [`PCG_UNIT_W-1:0] periph_acc_unit, // Unit accessed.
  input wire pcg_gates_s unit_clk_en, // Clock enables.
  input wire logic bus_fault, // Fault pulse.
  input wire logic [`PCG_UNIT_W-1:0] fault_unit // Last faulting unit.
);
  // ----------------------------------------------------------------
  // Helper terms
  // ----------------------------------------------------------------
  // Flattened enables and the fault cause; the index guard keeps units 9 to 15 out.
  logic [8:0] en_w;
  logic mapped;
  logic cause;
  assign en_w = unit_clk_en;
  assign mapped = paddr == ADDR_W'(`PCG_OFF_CFG) || paddr == ADDR_W'(`PCG_OFF_RUN1) ||
    paddr == ADDR_W'(`PCG_OFF_RUN2) || paddr == ADDR_W'(`PCG_OFF_DEEP1) ||
    paddr == ADDR_W'(`PCG_OFF_STAT);
  assign cause = periph_acc_valid && periph_acc_unit < 4'd9 && !en_w[periph_acc_unit];

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_run2_wr;
    psel && penable && pready && pwrite && paddr == ADDR_W'(`PCG_OFF_RUN2) && pstrb == 4'hf &&
      !sleep_req && !deep_sleep_req;
  endsequence

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_ready_after_setup: assert property (s_setup |=> pready)
    else $error("ready missing after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  a_slverr_map: assert property (pready |-> pslverr == !mapped)
    else $error("error flag wrong for address");
  a_run2_reserved: assert property (
    pready && !pwrite && paddr == ADDR_W'(`PCG_OFF_RUN2) |->
    (prdata & ~`PCG_MASK_RUN2) == 32'h0) else $error("run second reserved bits set");
  a_deep1_reserved: assert property (
    pready && !pwrite && paddr == ADDR_W'(`PCG_OFF_DEEP1) |->
    (prdata & ~`PCG_MASK_DEEP1) == 32'h0) else $error("deep first reserved bits set");
  a_run2_to_en: assert property (
    s_run2_wr |-> ##2 en_w[8:1] == {$past(pwdata[24], 2), $past(pwdata[18:16], 2),
    $past(pwdata[12], 2), $past(pwdata[4], 2), $past(pwdata[1:0], 2)})
    else $error("enables do not follow run second write");
  a_fault_set: assert property (cause |=>
    bus_fault && fault_unit == $past(periph_acc_unit))
    else $error("no fault for unclocked unit");
  a_fault_none: assert property (!cause |=> !bus_fault)
    else $error("fault without cause");
  a_unit_steady: assert property ($changed(fault_unit) |-> bus_fault)
    else $error("fault unit moved without fault");
  a_reset_gates: assert property ($rose(presetn) |-> en_w == 9'h000)
    else $error("enables not zero after reset");
endmodule : pcg_ctrl_checker

bind pcg_ctrl pcg_ctrl_checker #(.ADDR_W(ADDR_W)) u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleep_req(sleep_req),
  .deep_sleep_req(deep_sleep_req), .periph_acc_valid(periph_acc_valid),
  .periph_acc_unit(periph_acc_unit), .unit_clk_en(unit_clk_en), .bus_fault(bus_fault),
  .fault_unit(fault_unit));

`default_nettype wire

// ===== testbench/pcg_ctrl_tb.sv
// Self-checking bench for the clock gating controller.
// Assumes design, package, map header and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none

module pcg_ctrl_tb
  import pcg_pkg::*;
;
  typedef struct packed {
    logic [11:0] addr;
    logic [3:0] strb;
    logic [31:0] wdata;
    logic [31:0] exp;
    logic err;
  } pcg_row_s;

  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, bus_fault;
  logic sleep_req, deep_sleep_req, periph_acc_valid;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb, periph_acc_unit, fault_unit;
  pcg_gates_s sleep_gates, deep_sleep_gates, unit_clk_en;
  int num_errors, n_checks, cyc;
  // Write, then read back; a zero strobe and a single lane show byte masking.
  pcg_row_s rows [8] = '{
    '{12'h104, 4'hf, 32'hffff_ffff, 32'h0107_1013, 1'b0},
    '{12'h104, 4'h0, 32'h0000_0000, 32'h0107_1013, 1'b0},
    '{12'h104, 4'h2, 32'h0000_0000, 32'h0107_0013, 1'b0},
    '{12'h120, 4'hf, 32'hffff_ffff, 32'h0000_0008, 1'b0},
    '{12'h100, 4'hf, 32'hffff_fff7, 32'h0000_0000, 1'b0},
    '{12'h060, 4'hf, 32'hffff_fffe, 32'h0000_0000, 1'b0},
    '{12'h0fc, 4'hf, 32'hffff_ffff, 32'h0000_0000, 1'b1},
    '{12'h106, 4'hf, 32'hffff_ffff, 32'h0000_0000, 1'b1}};

  pcg_ctrl #(.ADDR_W(12)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sleep_req(sleep_req), .deep_sleep_req(deep_sleep_req),
    .sleep_gates(sleep_gates), .deep_sleep_gates(deep_sleep_gates),
    .periph_acc_valid(periph_acc_valid), .periph_acc_unit(periph_acc_unit),
    .unit_clk_en(unit_clk_en), .bus_fault(bus_fault), .fault_unit(fault_unit));

  // ----------------------------------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------------------------------
  // Clock at 200 MHz.
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // The whole run needs well under a thousand cycles; a hang ends here.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      test_done();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // One APB transfer; waits on pready and leaves an idle cycle behind.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
    input logic [3:0] s);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // One peripheral access, fault judged in the cycle after it is taken.
  task automatic acc(input logic [3:0] u, input logic f);
    periph_acc_valid <= 1'b1;
    periph_acc_unit <= u;
    @(posedge pclk);
    periph_acc_valid <= 1'b0;
    @(posedge pclk);
    check(32'(bus_fault), 32'(f));
    if (f === 1'b1) check(32'(fault_unit), 32'(u));
  endtask : acc

  task automatic en_is(input logic [8:0] e);
    repeat (3) @(posedge pclk);
    check(32'(unit_clk_en), 32'(e));
  endtask : en_is

  task test_done();
    $display("Comparisons %0d, mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, sleep_req, deep_sleep_req, periph_acc_valid} = 6'h00;
    {paddr, pwdata, pstrb, periph_acc_unit, cyc, num_errors, n_checks} = '0;
    sleep_gates = pcg_gates_s'(9'h0f0);
    deep_sleep_gates = pcg_gates_s'(9'h10e);
    presetn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rows[i]) begin
      apb(1'b0, rows[i].addr, 32'h0, 4'h0);
      check(rd, 32'h0);
    end
    foreach (rows[i]) begin
      apb(1'b1, rows[i].addr, rows[i].wdata, rows[i].strb);
      check(32'(err), 32'(rows[i].err));
      apb(1'b0, rows[i].addr, 32'h0, 4'h0);
      check(rd, rows[i].exp);
      check(32'(err), 32'(rows[i].err));
    end
    en_is(9'h1ee);
    // Watchdog and two-wire are off, so only units 0 and 4 may fault.
    for (int u = 0; u < 16; u++) begin
      acc(4'(u), u == 0 || u == 4);
    end
    apb(1'b0, 12'h130, 32'h0, 4'h0);
    check(rd, 32'h0041_01ee);
    apb(1'b1, 12'h130, 32'h0001_0000, 4'hf);
    apb(1'b0, 12'h130, 32'h0, 4'h0);
    check(rd, 32'h0040_01ee);
    sleep_req <= 1'b1;
    en_is(9'h1ee);
    apb(1'b1, 12'h060, 32'h0000_0001, 4'hf);
    en_is(9'h0f0);
    deep_sleep_req <= 1'b1;
    en_is(9'h10f);
    {sleep_req, deep_sleep_req} <= 2'b00;
    en_is(9'h1ee);
    // Software enables the watchdog by read-modify-write before it touches the unit.
    apb(1'b0, 12'h100, 32'h0, 4'h0);
    apb(1'b1, 12'h100, rd | 32'h0000_0008, 4'hf);
    apb(1'b0, 12'h100, 32'h0, 4'h0);
    check(rd, 32'h0000_0008);
    en_is(9'h1ef);
    acc(4'h0, 1'b0);
    // Reset in mid-run must clear every gate again.
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check(32'(unit_clk_en), 32'h0);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'h104, 32'h0, 4'h0);
    check(rd, 32'h0);
    apb(1'b0, 12'h120, 32'h0, 4'h0);
    check(rd, 32'h0);
    apb(1'b0, 12'h100, 32'h0, 4'h0);
    check(rd, 32'h0);
    test_done();
  end
endmodule : pcg_ctrl_tb

`default_nettype wire
